// file: rtl/dev_pinshare.sv
`timescale 1ns/1ps
`include "pinshare_defs.svh"
module dev_pinshare
    import pinshare_pkg::*;
#(
    parameter int NL = `PS_NUM_LINES,
    parameter int NI = `PS_NUM_IRQ
) (
    // Clock and power-on reset.
    input  wire logic          mclk_i,
    input  wire logic          rst_i,
    // Pin side.
    pinshare_if.dev            bus,
    // Memory controller.
    input  wire logic [31:0]   mc_addr_i,
    input  wire logic [2:0]    mc_baddr_i,
    // On-chip bus master.
    input  wire logic          mst_tenure_i,
    input  wire tenure_t       mst_attr_i,
    // Line selection writes.
    input  wire logic          sel_wr_i,
    input  wire logic [2:0]    sel_line_i,
    input  wire logic          sel_irq_i,
    input  wire logic [2:0]    sel_num_i,
    // Host port control writes.
    input  wire logic          pon_wr_i,
    input  wire logic          pon_val_i,
    // Upper data lines for the system bus.
    input  wire logic [31:0]   dhi_out_i,
    input  wire logic          dhi_drive_i,
    // Status and results.
    output logic [NI-1:0]      irq_req_o,
    output logic               snoop_valid_o,
    output tenure_t            snoop_attr_o,
    output logic               snoop_global_o,
    output logic               bus32_o,
    output logic               hdp_active_o,
    output logic               cfg_done_o,
    output logic               strap_o,
    output logic [31:0]        host_data_o
);
    logic                 strap_s;
    logic                 cfg_valid_s;
    logic [`PS_CFG_W-1:0] cfg_word_s;
    logic                 pon_set_s;
    logic [`PS_CFG_W-1:0] bus_control_reg;
    logic                 host_port_on_bit;
    logic [NL-1:0]        sel;
    logic [3*NL-1:0]      map;
    logic [NL-1:0]        line_s;
    logic                 ext_mode;
    logic                 own_q;
    logic                 mst_prev;
    tenure_t              own_attr;
    tenure_t              att_s;
    logic                 ten_s;
    logic                 ten_prev;
    logic [31:0]          dhi_s;
    logic [NI-1:0]        next_irq;

    // Pin inputs pass two flip-flops before any logic.
    sync2 #(.W(1)) u_strap (
        .mclk_i (mclk_i),
        .rst_i  (1'b0),
        .d_i    (bus.strap),
        .q_o    (strap_s)
    );
    sync2 #(.W(`PS_CFG_W + 2)) u_cfg (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .d_i    ({bus.cfg_valid, bus.pon_set, bus.cfg_word}),
        .q_o    ({cfg_valid_s, pon_set_s, cfg_word_s})
    );
    sync2 #(.W($bits(tenure_t) + 1)) u_att (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .d_i    ({bus.host_tenure, bus.att}),
        .q_o    ({ten_s, att_s})
    );
    sync2 #(.W(NL)) u_line (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .d_i    (bus.line),
        .q_o    (line_s)
    );
    sync2 #(.W(32)) u_dhi (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .d_i    (bus.dhi),
        .q_o    (dhi_s)
    );

    // Strap is caught only while reset is held.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            strap_o <= strap_s;
        end
    end

    // Configuration word: taken from the host when strapped, else default.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bus_control_reg <= `PS_CFG_DEF;
            cfg_done_o      <= 1'b0;
        end else if (!cfg_done_o) begin
            if (!strap_o) begin
                cfg_done_o <= 1'b1;
            end else if (cfg_valid_s) begin
                bus_control_reg <= cfg_word_s;
                cfg_done_o      <= 1'b1;
            end
        end
    end
    assign bus.cfg_ack = cfg_done_o;

    // Narrow bus when the size bit is set or the strap was seen.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bus32_o <= 1'b0;
        end else begin
            bus32_o <= bus_control_reg[`PS_CFG_BW32] | strap_o;
        end
    end
    assign ext_mode = bus_control_reg[`PS_CFG_EXTM];

    // Host port control; the port opens only on a narrowed bus.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            host_port_on_bit <= 1'b0;
        end else if (pon_wr_i) begin
            host_port_on_bit <= pon_val_i;
        end else if (pon_set_s) begin
            host_port_on_bit <= 1'b1;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            hdp_active_o <= 1'b0;
        end else begin
            hdp_active_o <= strap_o & cfg_done_o & bus32_o & host_port_on_bit;
        end
    end

    // Upper lines: host data port when open, system data only on a 64-bit bus.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bus.dhi_dev      <= '0;
            bus.dhi_dev_oe_n <= 1'b1;
            host_data_o      <= '0;
        end else begin
            bus.dhi_dev      <= dhi_out_i;
            bus.dhi_dev_oe_n <= !(dhi_drive_i && !bus32_o);
            if (hdp_active_o) begin
                host_data_o <= dhi_s;
            end
        end
    end

    // Line selection registers, default after every reset.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sel <= `PS_SEL_DEF;
            map <= `PS_MAP_DEF;
        end else if (sel_wr_i && 32'(sel_line_i) < NL) begin
            // Lines with a reserved primary cannot leave their alternates.
            sel[sel_line_i] <= sel_irq_i | (32'(sel_line_i) > `PS_LINE_BA31);
            map[3*sel_line_i +: 3] <= sel_num_i;
        end
    end

    // Each line set to interrupt use forwards its active-low request.
    always_comb begin
        next_irq = '0;
        for (int i = 0; i < NL; i++) begin
            if (sel[i] && !line_s[i]) begin
                next_irq[map[3*i +: 3]] = 1'b1;
            end
        end
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            irq_req_o <= '0;
        end else begin
            irq_req_o <= next_irq;
        end
    end

    // Own tenure: attributes are latched at its start and held.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            own_q    <= 1'b0;
            mst_prev <= 1'b0;
            own_attr <= '0;
        end else begin
            mst_prev <= mst_tenure_i;
            own_q    <= ext_mode & mst_tenure_i & cfg_done_o;
            if (mst_tenure_i && !mst_prev) begin
                own_attr <= mst_attr_i;
                if (mst_attr_i.burst) begin
                    own_attr.tsize <= `PS_BURST_SIZE;
                end
            end
        end
    end

    // Address lines: memory controller in internal mode, own tenure else.
    always_comb begin
        bus.att_dev                = own_attr;
        bus.att_dev_oe_n           = !own_q;
        bus.addr_only_dev_oe_n     = ext_mode;
        if (!ext_mode) begin
            bus.att_dev.addr = mc_addr_i;
        end
    end

    // Shared line outputs: global and burst address functions.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bus.line_dev      <= '1;
            bus.line_dev_oe_n <= '1;
        end else begin
            bus.line_dev_oe_n <= '1;
            bus.line_dev      <= '1;
            if (!sel[`PS_LINE_GLOB] && ext_mode && mst_tenure_i && cfg_done_o) begin
                bus.line_dev[`PS_LINE_GLOB]      <= !mst_attr_i.global;
                bus.line_dev_oe_n[`PS_LINE_GLOB] <= 1'b0;
            end
            for (int i = 0; i < 3; i++) begin
                if (!sel[`PS_LINE_BA29 + i]) begin
                    bus.line_dev[`PS_LINE_BA29 + i]      <= mc_baddr_i[i];
                    bus.line_dev_oe_n[`PS_LINE_BA29 + i] <= 1'b0;
                end
            end
        end
    end

    // Snoop external tenures; global marks a transfer to be snooped.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ten_prev       <= 1'b0;
            snoop_valid_o  <= 1'b0;
            snoop_attr_o   <= '0;
            snoop_global_o <= 1'b0;
        end else begin
            ten_prev      <= ten_s;
            snoop_valid_o <= 1'b0;
            if (ten_s && !ten_prev && ext_mode && !own_q) begin
                snoop_valid_o  <= 1'b1;
                snoop_attr_o   <= att_s;
                snoop_global_o <= !sel[`PS_LINE_GLOB] && !line_s[`PS_LINE_GLOB];
            end
        end
    end
endmodule

// file: rtl/host_pinshare.sv
`timescale 1ns/1ps
`include "pinshare_defs.svh"
module host_pinshare
    import pinshare_pkg::*;
#(
    parameter int NL = `PS_NUM_LINES
) (
    // Clock and reset.
    input  wire logic                 mclk_i,
    input  wire logic                 rst_i,
    // Pin side.
    pinshare_if.host                  bus,
    // Boot setup.
    input  wire logic                 strap_i,
    input  wire logic [`PS_CFG_W-1:0] cfg_word_i,
    input  wire logic                 pon_req_i,
    // External master tenure.
    input  wire logic                 ext_req_i,
    input  wire tenure_t              ext_attr_i,
    input  wire logic                 glob_line_i,
    // Interrupt sources and host data.
    input  wire logic [NL-1:0]        irq_drive_i,
    input  wire logic [31:0]          hdata_i,
    // Status.
    output logic                      ready_o,
    output logic                      pon_done_o
);
    host_state_t state;
    logic        ack_s;
    logic        size_q;
    logic        ten_q;
    logic        dev_busy_s;

    sync2 #(.W(2)) u_in (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .d_i    ({bus.cfg_ack, !bus.att_dev_oe_n}),
        .q_o    ({ack_s, dev_busy_s})
    );

    // Strap is held steady; the device samples it in reset.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bus.strap <= strap_i;
        end
    end

    // Configuration sequence, then the host port switch-on.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state         <= H_IDLE;
            bus.cfg_word  <= '0;
            bus.cfg_valid <= 1'b0;
            bus.pon_set   <= 1'b0;
            size_q        <= 1'b0;
            pon_done_o    <= 1'b0;
        end else begin
            unique case (state)
                H_IDLE: begin
                    if (bus.strap) begin
                        bus.cfg_word <= cfg_word_i | `PS_CFG_W'(1 << `PS_CFG_BW32);
                        bus.cfg_valid <= 1'b1;
                        size_q        <= 1'b1;
                        state         <= H_LOAD;
                    end else begin
                        state <= H_FREE;
                    end
                end
                H_LOAD: begin
                    if (ack_s) begin
                        bus.cfg_valid <= 1'b0;
                        state         <= H_READY;
                    end
                end
                H_READY: begin
                    if (pon_req_i && size_q) begin
                        bus.pon_set <= 1'b1;
                        pon_done_o  <= 1'b1;
                    end
                end
                H_FREE: begin
                    bus.pon_set <= 1'b0;
                end
            endcase
        end
    end
    assign ready_o = (state == H_READY) || (state == H_FREE);

    // External tenure: attributes latched at start and held throughout.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ten_q             <= 1'b0;
            bus.att_host      <= '0;
            bus.att_host_oe_n <= 1'b1;
            bus.host_tenure   <= 1'b0;
        end else begin
            ten_q <= ext_req_i && ready_o && !dev_busy_s;
            if (ext_req_i && ready_o && !dev_busy_s && !ten_q) begin
                bus.att_host <= ext_attr_i;
                if (ext_attr_i.burst) begin
                    bus.att_host.tsize <= `PS_BURST_SIZE;
                end
            end
            bus.att_host_oe_n <= !ten_q;
            bus.host_tenure   <= ten_q;
        end
    end

    // Lines: global on its line during own tenure, requests elsewhere.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bus.line_host      <= '1;
            bus.line_host_oe_n <= '1;
        end else begin
            bus.line_host      <= '0;
            bus.line_host_oe_n <= ~irq_drive_i;
            if (glob_line_i) begin
                bus.line_host[`PS_LINE_GLOB]      <= !ext_attr_i.global;
                bus.line_host_oe_n[`PS_LINE_GLOB] <= !(ext_req_i && ready_o);
            end
        end
    end

    // Host data on the upper lines once the port is on.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bus.dhi_host      <= '0;
            bus.dhi_host_oe_n <= 1'b1;
        end else begin
            bus.dhi_host      <= hdata_i;
            bus.dhi_host_oe_n <= !pon_done_o;
        end
    end
endmodule

// file: rtl/pinshare_defs.svh
`ifndef PINSHARE_DEFS_SVH
`define PINSHARE_DEFS_SVH

// Configuration word layout and reset value.
`define PS_CFG_W       16
`define PS_CFG_BW32    0
`define PS_CFG_EXTM    1
`define PS_CFG_DEF     16'h0002

// Shared line count, interrupt inputs and default line assignment.
`define PS_NUM_LINES   8
`define PS_NUM_IRQ     8
`define PS_SEL_DEF     8'hFE
`define PS_MAP_DEF     24'hFC9AD1

// Line indices with a bus or memory function.
`define PS_LINE_GLOB   0
`define PS_LINE_BA29   1
`define PS_LINE_BA31   3

// Size code driven with every burst of four quad words.
`define PS_BURST_SIZE  4'h0

`endif

// file: rtl/pinshare_if.sv
`timescale 1ns/1ps
`include "pinshare_defs.svh"
interface pinshare_if;
    import pinshare_pkg::*;

    // Strap and configuration word transfer.
    logic                     strap;
    logic [`PS_CFG_W-1:0]     cfg_word;
    logic                     cfg_valid;
    logic                     cfg_ack;
    logic                     pon_set;
    // Address tenure lines, one drive per party.
    tenure_t                  att_dev;
    logic                     att_dev_oe_n;
    logic                     addr_only_dev_oe_n;
    tenure_t                  att_host;
    logic                     att_host_oe_n;
    logic                     host_tenure;
    tenure_t                  att;
    // Shared interrupt and memory lines, pulled high.
    logic [`PS_NUM_LINES-1:0] line_dev;
    logic [`PS_NUM_LINES-1:0] line_dev_oe_n;
    logic [`PS_NUM_LINES-1:0] line_host;
    logic [`PS_NUM_LINES-1:0] line_host_oe_n;
    logic [`PS_NUM_LINES-1:0] line;
    // Upper 32 data lines.
    logic [31:0]              dhi_dev;
    logic                     dhi_dev_oe_n;
    logic [31:0]              dhi_host;
    logic                     dhi_host_oe_n;
    logic [31:0]              dhi;

    // Wire levels: device drive wins, then host, else the pull level.
    always_comb begin
        att = att_host_oe_n ? '0 : att_host;
        if (!att_dev_oe_n) begin
            att = att_dev;
        end else if (!addr_only_dev_oe_n) begin
            att.addr = att_dev.addr;
        end
        for (int i = 0; i < `PS_NUM_LINES; i++) begin
            line[i] = !line_dev_oe_n[i] ? line_dev[i] :
                      (!line_host_oe_n[i] ? line_host[i] : 1'b1);
        end
        dhi = !dhi_dev_oe_n ? dhi_dev : (!dhi_host_oe_n ? dhi_host : '0);
    end

    modport dev (
        input  strap, cfg_word, cfg_valid, pon_set, att, host_tenure, line, dhi,
        output cfg_ack, att_dev, att_dev_oe_n, addr_only_dev_oe_n,
        output line_dev, line_dev_oe_n, dhi_dev, dhi_dev_oe_n
    );
    modport host (
        input  cfg_ack, att, line, dhi, att_dev_oe_n,
        output strap, cfg_word, cfg_valid, pon_set, att_host, att_host_oe_n,
        output host_tenure, line_host, line_host_oe_n, dhi_host, dhi_host_oe_n
    );
endinterface

// file: rtl/pinshare_pkg.sv
package pinshare_pkg;

    // Address tenure attributes driven by the bus master.
    typedef struct packed {
        logic [31:0] addr;
        logic [4:0]  ttype;
        logic [3:0]  tsize;
        logic        burst;
        logic        global;
    } tenure_t;

    // Host configuration sequencer states.
    typedef enum logic [1:0] {
        H_IDLE  = 2'b00,
        H_LOAD  = 2'b01,
        H_READY = 2'b10,
        H_FREE  = 2'b11
    } host_state_t;

endpackage

// file: rtl/sync2.sv
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    // Asynchronous level in, synchronised level out.
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;

    // Two flip-flops; the first is read only by the second.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

// file: tb/pinshare_sva.sv
`timescale 1ns/1ps
`include "pinshare_defs.svh"
module pinshare_sva
    import pinshare_pkg::*;
(
    // Clock and reset.
    input wire logic    mclk_i,
    input wire logic    rst_i,
    // Configuration link.
    input wire logic    cfg_valid,
    input wire logic    cfg_ack,
    input wire logic    pon_set,
    // Address tenure.
    input wire tenure_t att_dev,
    input wire logic    att_dev_oe_n,
    input wire logic    addr_only_dev_oe_n,
    input wire logic    att_host_oe_n,
    input wire logic    host_tenure,
    input wire tenure_t att,
    // Upper data lines.
    input wire logic    dhi_dev_oe_n,
    input wire logic    dhi_host_oe_n
);
    // Every property runs on the bus clock and is quiet during reset.
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    // The word is offered, then taken within a few cycles.
    sequence s_cfg_offer;
        $rose(cfg_valid);
    endsequence
    sequence s_cfg_taken;
        ##[1:8] cfg_ack;
    endsequence
    // The device has held its attributes for two edges in a row.
    sequence s_dev_hold;
        !att_dev_oe_n ##1 !att_dev_oe_n;
    endsequence

    // Properties tie each output to its cause.
    property p_cfg_taken;
        s_cfg_offer |-> s_cfg_taken;
    endproperty
    property p_ack_stands;
        cfg_ack |=> cfg_ack;
    endproperty
    property p_valid_drop;
        cfg_ack && cfg_valid |-> ##[1:4] !cfg_valid;
    endproperty
    property p_pon_late;
        pon_set |-> cfg_ack;
    endproperty
    property p_one_master;
        !(!att_dev_oe_n && !att_host_oe_n);
    endproperty
    property p_att_steady;
        s_dev_hold |-> $stable(att_dev);
    endproperty
    property p_burst_size;
        !att_dev_oe_n && att_dev.burst |-> att_dev.tsize == `PS_BURST_SIZE;
    endproperty
    property p_addr_only;
        !addr_only_dev_oe_n |-> att_dev_oe_n && att.addr == att_dev.addr;
    endproperty
    property p_dhi_one;
        !(!dhi_dev_oe_n && !dhi_host_oe_n);
    endproperty
    property p_host_ten;
        $rose(host_tenure) |-> ##[0:1] !att_host_oe_n;
    endproperty

    a_cfg_taken: assert property (p_cfg_taken)
        else $error("configuration word not acknowledged");
    a_ack_stands: assert property (p_ack_stands)
        else $error("configuration acknowledge dropped");
    a_valid_drop: assert property (p_valid_drop)
        else $error("offer not withdrawn after acknowledge");
    a_pon_late: assert property (p_pon_late)
        else $error("host port asked on before width change");
    a_one_master: assert property (p_one_master)
        else $error("two masters drive the tenure");
    a_att_steady: assert property (p_att_steady)
        else $error("tenure attributes changed mid tenure");
    a_burst_size: assert property (p_burst_size)
        else $error("burst with wrong size code");
    a_addr_only: assert property (p_addr_only)
        else $error("internal mode address not from memory side");
    a_dhi_one: assert property (p_dhi_one)
        else $error("upper data lines driven twice");
    a_host_ten: assert property (p_host_ten)
        else $error("host tenure without drive");
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
`include "pinshare_defs.svh"
module tb_top
    import pinshare_pkg::*;
;
    // Bench drives, all given a value at time zero.
    logic        mclk_i       = 1'b0;
    logic        rst_i        = 1'b1;
    logic        strap_i      = 1'b0;
    logic [15:0] cfg_word_i   = '0;
    logic        pon_req_i    = 1'b0;
    logic        ext_req_i    = 1'b0;
    tenure_t     ext_attr_i   = '0;
    logic        glob_line_i  = 1'b0;
    logic [7:0]  irq_drive_i  = '0;
    logic [31:0] hdata_i      = '0;
    logic [31:0] mc_addr_i    = '0;
    logic [2:0]  mc_baddr_i   = '0;
    logic        mst_tenure_i = 1'b0;
    tenure_t     mst_attr_i   = '0;
    logic        sel_wr_i     = 1'b0;
    logic [2:0]  sel_line_i   = '0;
    logic        sel_irq_i    = 1'b0;
    logic [2:0]  sel_num_i    = '0;
    logic        pon_wr_i     = 1'b0;
    logic        pon_val_i    = 1'b0;
    logic [31:0] dhi_out_i    = '0;
    logic        dhi_drive_i  = 1'b0;
    // Design outputs and bench state.
    logic [7:0]  irq_req_o;
    logic        snoop_valid_o;
    tenure_t     snoop_attr_o;
    logic        snoop_global_o;
    logic        bus32_o;
    logic        hdp_active_o;
    logic        cfg_done_o;
    logic        strap_o;
    logic [31:0] host_data_o;
    logic        ready_o;
    logic        pon_done_o;
    int          n_fail = 0;
    int          checks = 0;
    tenure_t     exp_att;
    logic [7:0]  exp_irq [8] = '{8'h00, 8'h04, 8'h08, 8'h20, 8'h02, 8'h02, 8'h80, 8'h80};
    tenure_t     att_tab [2] = '{'{32'h1234_5678, 5'h0A, 4'h8, 1'b1, 1'b1},
                                 '{32'h0000_0FF0, 5'h01, 4'h4, 1'b0, 1'b1}};

    // The two ends face each other across the interface.
    pinshare_if pinshare_if_inst ();
    dev_pinshare dev_pinshare_inst (
        .mclk_i, .rst_i, .bus(pinshare_if_inst), .mc_addr_i, .mc_baddr_i, .mst_tenure_i,
        .mst_attr_i, .sel_wr_i, .sel_line_i, .sel_irq_i, .sel_num_i, .pon_wr_i, .pon_val_i,
        .dhi_out_i, .dhi_drive_i, .irq_req_o, .snoop_valid_o, .snoop_attr_o, .snoop_global_o,
        .bus32_o, .hdp_active_o, .cfg_done_o, .strap_o, .host_data_o
    );
    host_pinshare host_pinshare_inst (
        .mclk_i, .rst_i, .bus(pinshare_if_inst), .strap_i, .cfg_word_i, .pon_req_i,
        .ext_req_i, .ext_attr_i, .glob_line_i, .irq_drive_i, .hdata_i, .ready_o, .pon_done_o
    );
    pinshare_sva pinshare_sva_inst (
        .mclk_i, .rst_i,
        .cfg_valid(pinshare_if_inst.cfg_valid), .cfg_ack(pinshare_if_inst.cfg_ack),
        .pon_set(pinshare_if_inst.pon_set), .att_dev(pinshare_if_inst.att_dev),
        .att_dev_oe_n(pinshare_if_inst.att_dev_oe_n),
        .addr_only_dev_oe_n(pinshare_if_inst.addr_only_dev_oe_n),
        .att_host_oe_n(pinshare_if_inst.att_host_oe_n),
        .host_tenure(pinshare_if_inst.host_tenure), .att(pinshare_if_inst.att),
        .dhi_dev_oe_n(pinshare_if_inst.dhi_dev_oe_n),
        .dhi_host_oe_n(pinshare_if_inst.dhi_host_oe_n)
    );

    // Clock of 50 ns period.
    initial begin
        forever #25 mclk_i = ~mclk_i;
    end

    // Steps to 1 ns after a rising edge, where all drives change.
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    // Compares a seen value with the expected one and counts both outcomes.
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Power-on reset with a given strap and word, then waits for the word to land.
    task automatic do_reset(input logic s, input logic [15:0] w);
        int k;
        rst_i = 1'b1;
        strap_i = s;
        cfg_word_i = w;
        pon_req_i = 1'b0;
        tick(5);
        rst_i = 1'b0;
        for (k = 0; k < 30 && cfg_done_o !== 1'b1; k++) tick(1);
        for (k = 0; k < 30 && s && ready_o !== 1'b1; k++) tick(1);
    endtask

    // One write to a line selection, with a free edge after it.
    task automatic sel(input logic [2:0] ln, input logic irq, input logic [2:0] num);
        sel_wr_i = 1'b1;
        sel_line_i = ln;
        sel_irq_i = irq;
        sel_num_i = num;
        tick(1);
        sel_wr_i = 1'b0;
        tick(1);
    endtask

    // Drives one request line low and checks the resulting request vector.
    task automatic pull(input int ln, input logic [7:0] exp);
        irq_drive_i = 8'h01 << ln;
        tick(5);
        chk(irq_req_o, exp);
        irq_drive_i = '0;
        tick(5);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Cuts a hang short well past the expected run of some 215 cycles.
    initial begin
        repeat (3000) @(posedge mclk_i);
        n_fail++;
        end_of_test();
    end

    // Main sequence.
    initial begin
        int k;
        do_reset(1'b1, 16'h0002);
        chk(strap_o, 1'b1);
        chk(bus32_o, 1'b1);
        chk(ready_o, 1'b1);
        chk(cfg_done_o, 1'b1);
        pon_req_i = 1'b1;
        hdata_i = 32'hA5C3_0F96;
        for (k = 0; k < 20 && hdp_active_o !== 1'b1; k++) tick(1);
        tick(4);
        chk(hdp_active_o, 1'b1);
        chk(host_data_o, 32'hA5C3_0F96);
        chk(pon_done_o, 1'b1);
        // On-chip tenures, burst and single.
        for (k = 0; k < 2; k++) begin
            mst_attr_i = att_tab[k];
            exp_att = att_tab[k];
            if (exp_att.burst) exp_att.tsize = `PS_BURST_SIZE;
            mst_tenure_i = 1'b1;
            tick(3);
            chk(pinshare_if_inst.att, exp_att);
            chk(pinshare_if_inst.line[0], 1'b0);
            mst_tenure_i = 1'b0;
            tick(3);
        end
        // Host tenure seen by the snoop side.
        ext_attr_i = '{32'hCAFE_0040, 5'h02, 4'h8, 1'b0, 1'b1};
        glob_line_i = 1'b1;
        ext_req_i = 1'b1;
        for (k = 0; k < 20 && snoop_valid_o !== 1'b1; k++) tick(1);
        chk(snoop_valid_o, 1'b1);
        chk(snoop_attr_o[42:1], ext_attr_i[42:1]);
        chk(snoop_global_o, 1'b1);
        ext_req_i = 1'b0;
        glob_line_i = 1'b0;
        tick(4);
        for (k = 0; k < 8; k++) pull(k, exp_irq[k]);
        // Burst address function on lines 1 to 3.
        mc_baddr_i = 3'b101;
        for (k = 1; k < 4; k++) sel(k[2:0], 1'b0, 3'h0);
        chk(pinshare_if_inst.line[3:1], 3'b101);
        mc_baddr_i = 3'b010;
        tick(2);
        chk(pinshare_if_inst.line[3:1], 3'b010);
        pull(1, 8'h00);
        sel(3'd4, 1'b1, 3'd3);
        pull(4, 8'h08);
        // A line whose primary is reserved stays an interrupt line.
        sel(3'd5, 1'b0, 3'd6);
        pull(5, 8'h40);
        // No strap: 64-bit bus, port stays off, defaults back.
        do_reset(1'b0, 16'h0000);
        chk(strap_o, 1'b0);
        chk(bus32_o, 1'b0);
        // On a 64-bit bus the upper lines carry system data.
        dhi_out_i = 32'h5A3C_F00F;
        dhi_drive_i = 1'b1;
        tick(2);
        chk(pinshare_if_inst.dhi, 32'h5A3C_F00F);
        dhi_drive_i = 1'b0;
        pon_val_i = 1'b1;
        pon_wr_i = 1'b1;
        tick(1);
        pon_wr_i = 1'b0;
        tick(3);
        chk(hdp_active_o, 1'b0);
        pull(4, 8'h02);
        pull(1, 8'h04);
        // Internal-master mode: address from the memory side only.
        do_reset(1'b1, 16'h0001);
        mc_addr_i = 32'h0C0F_FEE0;
        mst_attr_i = att_tab[1];
        mst_tenure_i = 1'b1;
        tick(3);
        chk(pinshare_if_inst.att.addr, 32'h0C0F_FEE0);
        chk(pinshare_if_inst.att_dev_oe_n, 1'b1);
        chk(pinshare_if_inst.addr_only_dev_oe_n, 1'b0);
        mst_tenure_i = 1'b0;
        tick(3);
        end_of_test();
    end
endmodule
